/* File: shared/tirq_pkg.sv */
// Package: register map, field layout and carrier types of the timer interrupt flag block
package tirq_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] TIRQ_ENABLE_OFF  = 12'h000;
	localparam logic [11:0] TIRQ_STATUS_OFF  = 12'h004;
	localparam logic [11:0] TIRQ_FUNC_OFF    = 12'h008;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int TIRQ_WRAP_BIT   = 7;
	localparam int TIRQ_CHAN_D_BIT = 3;
	localparam int TIRQ_CHAN_C_BIT = 2;
	localparam int TIRQ_CHAN_B_BIT = 1;
	localparam int TIRQ_CHAN_A_BIT = 0;

	// Bits 6..4 unimplemented, read as 1
	localparam logic [7:0] TIRQ_RSVD_MASK  = 8'h70;
	localparam logic [7:0] TIRQ_IMPL_MASK  = 8'h8F;
	localparam logic [7:0] TIRQ_EN_RESET   = 8'h00;
	localparam logic [7:0] TIRQ_ST_RESET   = 8'h00;
	localparam logic [3:0] TIRQ_FUNC_RESET = 4'h0;
	localparam logic [15:0] TIRQ_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TIRQ_COUNT_MIN = 16'h0000;

	// ----------------------------------------
	// Carrier types
	// ----------------------------------------
	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} tirq_apb_req_t;

	// Per channel: index 3 = D ... 0 = A
	typedef struct packed {
		logic [15:0] timer_count;
		logic [3:0]  compare_equal;
		logic [3:0]  capture_strobe;
	} tirq_timer_evt_t;

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] status;
		logic [7:0] armed;
		logic [3:0] capture_select;
		logic [15:0] prev_count;
		logic       count_valid;
	} tirq_state_t;

endpackage

/* File: src/tirq_flags.sv */
// Timer interrupt enable and status flags with APB register access
`timescale 1ns/10ps

// How it works
// R1 - Wrap request needs enable bit 7 and flag
// R2 - Channel D request needs enable bit 3
// R3 - Channel C request needs enable bit 2
// R4 - Channel B request needs enable bit 1
// R5 - Channel A request needs enable bit 0
// R6 - Bits 6 to 4 read one, ignore writes
// R7 - Counter wrap FFFF to 0000 sets bit 7
// R8 - Wrap flag cleared by read-one then write-zero
// R9 - Compare equal D sets bit 3
// R10 - Capture into D sets bit 3
// R11 - Channel D cleared by read-one then write-zero
// R12 - Compare equal C sets bit 2
// R13 - Capture into C sets bit 2
// R14 - Channel C cleared by read-one then write-zero
// R15 - Compare equal B sets bit 1
// R16 - Capture into B sets bit 1
// R17 - Channel B cleared by read-one then write-zero
// R18 - Compare equal A sets bit 0
// R19 - Capture into A sets bit 0
// R20 - Channel A cleared by read-one then write-zero
// R21 - Select bit 0 compare, 1 capture
// R22 - Enables and flags zero after reset
module tirq_flags (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire tirq_pkg::tirq_timer_evt_t timer_evt,
	output logic                           overflow_irq_req,
	output logic                           chan_d_irq_req,
	output logic                           chan_c_irq_req,
	output logic                           chan_b_irq_req,
	output logic                           chan_a_irq_req
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] read_byte(input logic [7:0] v);
		read_byte = {24'h000000, v};
	endfunction

	tirq_pkg::tirq_state_t state_reg;
	tirq_pkg::tirq_state_t state_next;

	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit_en;
	logic        hit_st;
	logic        hit_fn;
	logic [7:0]  set_evt;
	logic [3:0]  cmp_gate;
	logic [3:0]  cap_gate;
	logic [7:0]  st_view;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	assign acc     = psel & penable;
	assign wr      = acc & pwrite & pstrb[0];
	assign rd      = acc & ~pwrite;
	assign hit_en  = (paddr == tirq_pkg::TIRQ_ENABLE_OFF);
	assign hit_st  = (paddr == tirq_pkg::TIRQ_STATUS_OFF);
	assign hit_fn  = (paddr == tirq_pkg::TIRQ_FUNC_OFF);
	assign pready  = 1'b1;
	assign pslverr = acc & ~(hit_en | hit_st | hit_fn);

	// ----------------------------------------
	// Event sources
	// ----------------------------------------
	// Compare counts only in compare mode, capture only in capture mode
	assign cmp_gate = timer_evt.compare_equal & ~state_reg.capture_select; // R21 R9 R12 R15 R18
	assign cap_gate = timer_evt.capture_strobe & state_reg.capture_select; // R21 R10 R13 R16 R19
	always_comb begin
		set_evt = 8'h00;
		// Wrap seen as previous max followed by zero
		set_evt[tirq_pkg::TIRQ_WRAP_BIT] = state_reg.count_valid
			& (state_reg.prev_count == tirq_pkg::TIRQ_COUNT_MAX)
			& (timer_evt.timer_count == tirq_pkg::TIRQ_COUNT_MIN); // R7
		set_evt[3:0] = cmp_gate | cap_gate;
	end

	assign st_view = state_reg.status | tirq_pkg::TIRQ_RSVD_MASK; // R6

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.prev_count  = timer_evt.timer_count;
		state_next.count_valid = 1'b1;
		if (wr && hit_en) begin
			state_next.enable = pwdata[7:0] & tirq_pkg::TIRQ_IMPL_MASK; // R6
		end
		if (wr && hit_fn) begin
			state_next.capture_select = pwdata[3:0];
		end
		// Arm a flag when read as one; only armed bits may clear
		if (rd && hit_st) begin
			state_next.armed = state_reg.armed | state_reg.status; // R8 R11 R14 R17 R20
		end
		if (wr && hit_st) begin
			state_next.status = state_reg.status & ~(state_reg.armed & ~pwdata[7:0]); // R8 R11 R14 R17 R20
			state_next.armed  = 8'h00;
		end
		// A new event beats a clear in the same cycle
		state_next.status = (state_next.status | set_evt) & tirq_pkg::TIRQ_IMPL_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.enable         <= tirq_pkg::TIRQ_EN_RESET; // R22
			state_reg.status         <= tirq_pkg::TIRQ_ST_RESET; // R22
			state_reg.armed          <= 8'h00;
			state_reg.capture_select <= tirq_pkg::TIRQ_FUNC_RESET;
			state_reg.prev_count     <= 16'h0000;
			state_reg.count_valid    <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Read data and requests
	// ----------------------------------------
	always_comb begin
		prdata = 32'h00000000;
		if (hit_en) begin
			prdata = read_byte(state_reg.enable | tirq_pkg::TIRQ_RSVD_MASK); // R6
		end else if (hit_st) begin
			prdata = read_byte(st_view);
		end else if (hit_fn) begin
			prdata = {28'h0000000, state_reg.capture_select};
		end
	end

	assign overflow_irq_req = state_reg.enable[tirq_pkg::TIRQ_WRAP_BIT] & state_reg.status[tirq_pkg::TIRQ_WRAP_BIT]; // R1
	assign chan_d_irq_req = state_reg.enable[tirq_pkg::TIRQ_CHAN_D_BIT] & state_reg.status[tirq_pkg::TIRQ_CHAN_D_BIT]; // R2
	assign chan_c_irq_req = state_reg.enable[tirq_pkg::TIRQ_CHAN_C_BIT] & state_reg.status[tirq_pkg::TIRQ_CHAN_C_BIT]; // R3
	assign chan_b_irq_req = state_reg.enable[tirq_pkg::TIRQ_CHAN_B_BIT] & state_reg.status[tirq_pkg::TIRQ_CHAN_B_BIT]; // R4
	assign chan_a_irq_req = state_reg.enable[tirq_pkg::TIRQ_CHAN_A_BIT] & state_reg.status[tirq_pkg::TIRQ_CHAN_A_BIT]; // R5

endmodule

/* File: verification/tirq_flags_assertions.sv */
// Port assertions for the timer interrupt flag block
`timescale 1ns/10ps
module tirq_flags_chk (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [11:0]               paddr,
	input wire logic [31:0]               prdata,
	input wire logic                      pslverr,
	input wire tirq_pkg::tirq_timer_evt_t timer_evt,
	input wire logic                      overflow_irq_req,
	input wire logic                      chan_a_irq_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rd_st = acc && !pwrite && paddr == 12'h004;
	wire en_wr = acc && pwrite && paddr == 12'h000;
	a_rsvd_ones: assert property (acc && !pwrite && (paddr == 12'h000 || rd_st) |-> prdata[6:4] == 3'h7)
		else $error("reserved bits not one");
	a_unmapped_err: assert property (acc && paddr > 12'h008 |-> pslverr)
		else $error("no error on unmapped");
	// Wrap may land one or two edges after zero is seen
	a_wrap_rise: assert property ($rose(overflow_irq_req) |-> $past(en_wr) || $past(timer_evt.timer_count) == 16'h0000 || $past(timer_evt.timer_count, 2) == 16'h0000)
		else $error("wrap request without cause");
	a_wrap_fall: assert property ($fell(overflow_irq_req) |-> $past(acc && pwrite))
		else $error("wrap request dropped alone");
	a_chan_rise: assert property ($rose(chan_a_irq_req) |-> $past(en_wr || timer_evt.compare_equal[0] || timer_evt.capture_strobe[0]))
		else $error("channel request without cause");
	a_chan_fall: assert property ($fell(chan_a_irq_req) |-> $past(acc && pwrite))
		else $error("channel request dropped alone");
	a_wrap_flag: assert property (overflow_irq_req && rd_st |-> prdata[7])
		else $error("wrap request without flag");
	a_chan_flag: assert property (chan_a_irq_req && rd_st |-> prdata[0])
		else $error("channel request without flag");
endmodule

/* File: verification/tirq_irq_sink.sv */
// Model of the processor side taking the timer requests
`timescale 1ns/10ps
module tirq_irq_sink (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [4:0] irq_req,
	output logic      [4:0] irq_seen
);
	// Sticky, since a level request may be short
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_seen <= 5'h00;
		end else begin
			irq_seen <= irq_seen | irq_req;
		end
	end
endmodule

/* File: verification/testbench.sv */
// Testbench for the timer interrupt flag block
`timescale 1ns/10ps
module testbench;
	logic                      pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0]               paddr = 12'h000;
	logic [31:0]               pwdata = 32'h0, prdata, rd;
	logic [3:0]                pstrb = 4'hF, one;
	logic                      pready, pslverr, err;
	logic [4:0]                req, seen;
	tirq_pkg::tirq_timer_evt_t timer_evt = '0;
	int                        n_fail = 0, checks_done = 0;
	always #5 pclk = ~pclk;
	tirq_flags dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .timer_evt, .overflow_irq_req(req[4]), .chan_d_irq_req(req[3]), .chan_c_irq_req(req[2]),
		.chan_b_irq_req(req[1]), .chan_a_irq_req(req[0]));
	tirq_irq_sink sink_u (.pclk, .presetn, .irq_req(req), .irq_seen(seen));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic pulse(input logic [3:0] ce, input logic [3:0] cs);
		timer_evt.compare_equal <= ce;
		timer_evt.capture_strobe <= cs;
		@(posedge pclk);
		timer_evt.compare_equal <= 4'h0;
		timer_evt.capture_strobe <= 4'h0;
		@(posedge pclk);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		bus(1'h0, tirq_pkg::TIRQ_STATUS_OFF, 8'h00); chk("status", 32'h70, rd);
		bus(1'h1, tirq_pkg::TIRQ_ENABLE_OFF, 8'hFF);
		bus(1'h0, tirq_pkg::TIRQ_ENABLE_OFF, 8'h00); chk("enable", 32'hFF, rd);
		bus(1'h0, 12'h00C, 8'h00); chk("unmapped", 32'h1, {31'h0, err});
		for (int m = 0; m < 2; m++) begin
			bus(1'h1, tirq_pkg::TIRQ_FUNC_OFF, m ? 8'h0F : 8'h00);
			for (int i = 0; i < 4; i++) begin
				one = 4'(1 << i);
				pulse(m ? one : 4'h0, m ? 4'h0 : one); chk("wrong kind", 32'h0, {27'h0, req});
				pulse(m ? 4'h0 : one, m ? one : 4'h0); chk("req", 32'h1 << i, {27'h0, req});
				bus(1'h1, tirq_pkg::TIRQ_STATUS_OFF, 8'h00); chk("no clear", 32'h1 << i, {27'h0, req});
				bus(1'h0, tirq_pkg::TIRQ_STATUS_OFF, 8'h00);
				bus(1'h1, tirq_pkg::TIRQ_STATUS_OFF, 8'h00); chk("cleared", 32'h0, {27'h0, req});
			end
		end
		bus(1'h0, tirq_pkg::TIRQ_FUNC_OFF, 8'h00); chk("select", 32'h0F, rd);
		chk("mapped err", 32'h0, {31'h0, err});
		pstrb <= 4'h0;
		bus(1'h1, tirq_pkg::TIRQ_ENABLE_OFF, 8'h00);
		pstrb <= 4'hF;
		bus(1'h0, tirq_pkg::TIRQ_ENABLE_OFF, 8'h00); chk("strobe off", 32'hFF, rd);
		timer_evt.timer_count <= 16'hFFFF;
		@(posedge pclk);
		timer_evt.timer_count <= 16'h0000;
		@(posedge pclk);
		timer_evt.timer_count <= 16'h0001;
		repeat (2) @(posedge pclk);
		chk("wrap", 32'h10, {27'h0, req});
		bus(1'h1, tirq_pkg::TIRQ_ENABLE_OFF, 8'h0F); chk("masked", 32'h0, {27'h0, req});
		bus(1'h0, tirq_pkg::TIRQ_STATUS_OFF, 8'h00); chk("wrap flag", 32'hF0, rd);
		bus(1'h1, tirq_pkg::TIRQ_STATUS_OFF, 8'h00);
		bus(1'h0, tirq_pkg::TIRQ_STATUS_OFF, 8'h00); chk("wrap clear", 32'h70, rd);
		chk("seen", 32'h1F, {27'h0, seen});
		complete_run;
	end
	// Whole sequence needs about 150 cycles
	initial begin
		#100000;
		n_fail++;
		complete_run;
	end
endmodule
bind tirq_flags tirq_flags_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
	.timer_evt, .overflow_irq_req, .chan_a_irq_req);
